/* design/trs_pkg.sv */
// Package: constants and types for the targeted row refresh sequencer
package trs_pkg;
    // ==========================================
    // Control register layout
    localparam logic [7:0] CTRL_RESET     = 8'h00;
    localparam int         CTRL_EN_BIT    = 7;
    localparam int         CTRL_BANK_HI   = 6;
    localparam int         CTRL_BANK_LO   = 4;
    localparam int         CTRL_UNLIM_BIT = 3;
    localparam logic [2:0] MAC_UNLIMITED  = 3'h0;

    // ==========================================
    // Timing
    localparam int CLK_PERIOD_PS      = 8000;
    localparam int MODE_WRITE_DELAY_NS = 14;
    localparam int MODE_WRITE_DELAY_CYC =
        ((MODE_WRITE_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS) < 1 ? 1 :
        ((MODE_WRITE_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam int ROW_PRECHARGE_TIME_NS = 18;
    localparam int ROW_PRECHARGE_CYC =
        ((ROW_PRECHARGE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS) < 1 ? 1 :
        ((ROW_PRECHARGE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam int CNT_W = 8;

    // ==========================================
    // Decoded command codes
    typedef enum logic [2:0] {
        CMD_NOP  = 3'h0,
        CMD_ACT  = 3'h1,
        CMD_PRE  = 3'h2,
        CMD_PRECHARGE_ALL_BANKS = 3'h3,
        CMD_MRW  = 3'h4,
        CMD_REF  = 3'h5
    } trs_cmd_t;

    // One command from the host
    typedef struct packed {
        logic       valid;
        trs_cmd_t   op;
        logic [2:0] bank;
        logic [7:0] data;   // Mode write payload
    } trs_req_t;

    // Sequencer states, Gray coded along the main path
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_ENTRY = 3'b001,
        ST_ARMED = 3'b011,
        ST_ROWON = 3'b010,
        ST_ROWOF = 3'b110,
        ST_DRAIN = 3'b111
    } trs_state_t;
endpackage

/* design/trs_delay.sv */
// Reloadable down counter used for the mode-write and precharge waits
`timescale 1ns/100ps
`default_nettype none
module trs_delay #(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic         mclk_i,
    input  wire logic         rst_n_i,
    // Control
    input  wire logic         load_i,
    input  wire logic [W-1:0] count_i,
    // Status
    output logic              done_o
);
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;

    // Count down to zero and hold there
    assign cnt_d  = load_i ? count_i : (cnt_q != '0 ? cnt_q - W'(1) : cnt_q);
    assign done_o = (cnt_q == '0) && !load_i;

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule
`default_nettype wire

/* design/trs_seq.sv */
// Device-side targeted row refresh mode control and victim restore
`timescale 1ns/100ps
`default_nettype none
// Contract
// - Unlimited count: enable bit is ignored
// - Bit 7 enables mode, bits 6:4 bank
// - Self-clear after third precharge plus delay
// - Host may disable; bank bits ignored
// - Three activates, three precharges; all counts
// - Mode activates leave refresh counter alone
// - Device restores victim rows during mode
module trs_seq
    import trs_pkg::*;
#(
    parameter int BANKS = 8
) (
    // Clock and reset
    input  wire logic              mclk_i,
    input  wire logic              rst_n_i,
    // Decoded host command
    input  wire trs_pkg::trs_req_t req_i,
    // Register read back and mode status
    output logic [7:0]             ctrl_o,
    output logic                   mode_active_o,
    output logic [2:0]             acts_done_o,
    output logic [2:0]             pres_done_o,
    // Victim restore and refresh counter
    output logic                   restore_pulse_o,
    output logic [2:0]             restore_bank_o,
    output logic                   refresh_step_o
);
    import trs_pkg::*;

    // ==========================================
    // Storage
    trs_state_t state_q, state_d;
    logic [7:0] ctrl_q, ctrl_d;
    logic [2:0] acts_q, acts_d;
    logic [2:0] pres_q, pres_d;
    logic       restore_q, refresh_q;
    logic [2:0] rbank_q;
    logic       mode_q;

    // ==========================================
    // Helpers
    // Count field of zero with the flag bit set means activates are not
    // limited, so no run is needed and an enable only parks in the register
    function automatic logic unlim(input logic [7:0] v);
        return v[2:0] == MAC_UNLIMITED && v[CTRL_UNLIM_BIT];
    endfunction

    // Match against the stored aggressor bank; a bank number past the
    // configured count is never sequenced, so a part built with fewer banks
    // cannot be steered onto a bank it does not have
    function automatic logic on_bank(input logic [2:0] b, input logic [2:0] agg);
        return b == agg && int'(agg) < BANKS;
    endfunction

    // ==========================================
    // Command decode
    wire logic       is_mrw   = req_i.valid && req_i.op == CMD_MRW;
    wire logic       is_act   = req_i.valid && req_i.op == CMD_ACT;
    wire logic       is_ref   = req_i.valid && req_i.op == CMD_REF;
    wire logic [2:0] agg_bank = ctrl_q[CTRL_BANK_HI:CTRL_BANK_LO];
    // A precharge-all always closes the aggressor bank too
    wire logic hit_pre = req_i.valid && ((req_i.op == CMD_PRE && on_bank(req_i.bank, agg_bank))
                                         || req_i.op == CMD_PRECHARGE_ALL_BANKS);
    wire logic hit_act = is_act && on_bank(req_i.bank, agg_bank);
    // Unlimited activate count makes the sequence unnecessary; enable has no effect.
    // The mode flag is taken from the next register value so that the output
    // comes from its own flip-flop with no extra cycle of lag.
    wire logic mode_d    = ctrl_d[CTRL_EN_BIT] && !unlim(ctrl_d);
    wire logic in_mode   = state_q != ST_IDLE;
    wire logic wr_en     = is_mrw && req_i.data[CTRL_EN_BIT];
    wire logic wr_dis    = is_mrw && !req_i.data[CTRL_EN_BIT];

    // Waits: mode-write delay after entry, precharge plus delay at the end
    logic       dly_load;
    logic [CNT_W-1:0] dly_cnt;
    logic       dly_done;
    trs_delay #(.W(CNT_W)) u_delay (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .load_i  (dly_load),
        .count_i (dly_cnt),
        .done_o  (dly_done)
    );

    // ==========================================
    // Sequencer next state
    // A disable write is checked first so that an abort always lands, even
    // in the middle of a run; enable writes during a run fall through and
    // are dropped, which is what the host is told to expect
    always_comb begin
        state_d  = state_q;
        ctrl_d   = ctrl_q;
        acts_d   = acts_q;
        pres_d   = pres_q;
        dly_load = 1'b0;
        dly_cnt  = CNT_W'(MODE_WRITE_DELAY_CYC);
        if (wr_dis) begin
            // Disable wins at any point; bank bits are not taken
            ctrl_d[CTRL_EN_BIT] = 1'b0;
            state_d = ST_IDLE;
            acts_d  = 3'h0;
            pres_d  = 3'h0;
        end else if (wr_en && !in_mode) begin
            // An idle enable stores the whole byte; the host keeps the other bits
            ctrl_d = req_i.data;
            if (!unlim(req_i.data)) begin
                state_d  = ST_ENTRY;
                dly_load = 1'b1;
            end
        end else if (is_mrw && !in_mode) begin
            ctrl_d = req_i.data;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                end
                ST_ENTRY: begin
                    // Activates before the wait runs out are dropped, not queued
                    if (dly_done) state_d = ST_ARMED;
                end
                ST_ARMED: begin
                    if (hit_act) begin
                        acts_d  = acts_q + 3'h1;
                        state_d = ST_ROWON;
                    end
                end
                ST_ROWON: begin
                    // Only a precharge after a counted activate advances the count
                    if (hit_pre) begin
                        pres_d = pres_q + 3'h1;
                        if (pres_q == 3'h2) begin
                            state_d  = ST_DRAIN;
                            dly_load = 1'b1;
                            dly_cnt  = CNT_W'(ROW_PRECHARGE_CYC + MODE_WRITE_DELAY_CYC);
                        end else begin
                            state_d = ST_ROWOF;
                        end
                    end
                end
                ST_ROWOF: begin
                    if (hit_act) begin
                        acts_d  = acts_q + 3'h1;
                        state_d = ST_ROWON;
                    end
                end
                ST_DRAIN: begin
                    // Self-clear once precharge and mode-write delay have run out
                    // The host may still abort here; that path is handled above
                    if (dly_done) begin
                        state_d = ST_IDLE;
                        ctrl_d[CTRL_EN_BIT] = 1'b0;
                        acts_d  = 3'h0;
                        pres_d  = 3'h0;
                    end
                end
                default: state_d = ST_IDLE;
            endcase
        end
    end

    // ==========================================
    // State registers
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            state_q <= ST_IDLE;
            ctrl_q  <= CTRL_RESET;
            acts_q  <= 3'h0;
            pres_q  <= 3'h0;
            mode_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            ctrl_q  <= ctrl_d;
            acts_q  <= acts_d;
            pres_q  <= pres_d;
            mode_q  <= mode_d;
        end
    end

    // ==========================================
    // Victim restore and refresh counter stepping
    // A mode activate restores neighbours of the aggressor row but never
    // advances the regular refresh counter; outside the mode a refresh does.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            restore_q <= 1'b0;
            rbank_q   <= 3'h0;
            refresh_q <= 1'b0;
        end else begin
            restore_q <= hit_act && (state_q == ST_ARMED || state_q == ST_ROWOF);
            rbank_q   <= agg_bank;
            refresh_q <= is_ref && !in_mode;
        end
    end

    // ==========================================
    // Outputs straight from flip-flops
    // so downstream timing sees no decode logic behind any pin
    assign ctrl_o          = ctrl_q;
    assign mode_active_o   = mode_q;
    assign acts_done_o     = acts_q;
    assign pres_done_o     = pres_q;
    assign restore_pulse_o = restore_q;
    assign restore_bank_o  = rbank_q;
    assign refresh_step_o  = refresh_q;
endmodule
`default_nettype wire

/* dv/trs_host.sv */
// Host command model that drives the targeted refresh sequencer
`timescale 1ns/100ps
`default_nettype none
module trs_host (
    // Clock
    input  wire logic         mclk_i,
    // Command to the device
    output var trs_pkg::trs_req_t req_o
);
    import trs_pkg::*;
    initial req_o = '0;
    // One command for one cycle; while idle the op goes to NOP and bank and data go to the inverse so stale values never match
    task automatic send(input trs_cmd_t op, input logic [2:0] b, input logic [7:0] d, input int gap);
        @(negedge mclk_i);
        req_o = {1'b1, op, b, d};
        @(negedge mclk_i);
        req_o = {1'b0, CMD_NOP, ~b, ~d};
        repeat (gap) @(negedge mclk_i);
    endtask
    // Entry to completion; the gaps stand in for the row times at this clock
    task automatic trr_run(input logic [2:0] b, input logic use_all);
        send(CMD_MRW, b, {1'b1, b, 4'h0}, MODE_WRITE_DELAY_CYC);
        send(CMD_ACT, b, 8'h00, 3);
        send(CMD_PRE, b, 8'h00, ROW_PRECHARGE_CYC);
        send(CMD_ACT, b, 8'h00, 2);
        send(CMD_PRE, b, 8'h00, ROW_PRECHARGE_CYC);
        send(CMD_ACT, b, 8'h00, 2);
        send(use_all ? CMD_PRECHARGE_ALL_BANKS : CMD_PRE, b, 8'h00, 1);
    endtask
    // Clear an interrupted run; bank bits of the write are ignored
    task automatic trr_abort(input logic [2:0] b);
        send(CMD_MRW, ~b, 8'h70, 1);
        repeat (3) send(CMD_PRE, b, 8'h00, ROW_PRECHARGE_CYC);
    endtask
endmodule
`default_nettype wire

/* dv/trs_seq_assertions.sv */
// Port checker for the targeted refresh sequencer
`timescale 1ns/100ps
`default_nettype none
module trs_seq_chk (
    // Clock and reset
    input wire logic              mclk_i,
    input wire logic              rst_n_i,
    // Watched ports
    input wire trs_pkg::trs_req_t req_i,
    input wire logic [7:0]        ctrl_o,
    input wire logic              mode_active_o,
    input wire logic [2:0]        acts_done_o,
    input wire logic [2:0]        pres_done_o,
    input wire logic              restore_pulse_o,
    input wire logic [2:0]        restore_bank_o,
    input wire logic              refresh_step_o
);
    import trs_pkg::*;
    // Decoded commands
    wire logic [7:0] wdata = req_i.data;
    wire logic mrw = req_i.valid && req_i.op == CMD_MRW;
    wire logic hit = req_i.valid && req_i.op == CMD_ACT && req_i.bank == restore_bank_o && mode_active_o;
    wire logic precharge_all_banks = req_i.valid && req_i.op == CMD_PRECHARGE_ALL_BANKS && mode_active_o;
    wire logic refr = req_i.valid && req_i.op == CMD_REF;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    property p_on; mrw && wdata[7] && !ctrl_o[7] |=> ctrl_o == $past(wdata); endproperty
    a_on: assert property (p_on) else $error("entry write not stored");
    property p_off; mrw && !wdata[7] |=> !ctrl_o[7] && ctrl_o[6:0] == $past(ctrl_o[6:0]); endproperty
    a_off: assert property (p_off) else $error("disable write wrong");
    property p_unl; ctrl_o[3] && ctrl_o[2:0] == MAC_UNLIMITED |-> !mode_active_o; endproperty
    a_unl: assert property (p_unl) else $error("mode on with unlimited count");
    property p_clr; pres_done_o == 3'h3 |-> ##[1:8] !ctrl_o[7]; endproperty
    a_clr: assert property (p_clr) else $error("no self clear");
    property p_act; acts_done_o > $past(acts_done_o) |-> $past(hit); endproperty
    a_act: assert property (p_act) else $error("activate miscounted");
    property p_precharge_all_banks; precharge_all_banks && pres_done_o < acts_done_o |=> pres_done_o == $past(pres_done_o) + 3'h1; endproperty
    a_precharge_all_banks: assert property (p_precharge_all_banks) else $error("precharge all not counted");
    property p_rst; acts_done_o > $past(acts_done_o) |-> restore_pulse_o ##1 !restore_pulse_o; endproperty
    a_rst: assert property (p_rst) else $error("restore pulse wrong");
    property p_ref; mode_active_o && refr |=> !refresh_step_o ##1 !refresh_step_o; endproperty
    a_ref: assert property (p_ref) else $error("refresh stepped in mode");
    c_done: cover property (pres_done_o == 3'h3);
    c_rest: cover property (restore_pulse_o);
    c_step: cover property (refresh_step_o);
endmodule
bind trs_seq trs_seq_chk u_chk (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .req_i(req_i), .ctrl_o(ctrl_o),
    .mode_active_o(mode_active_o), .acts_done_o(acts_done_o), .pres_done_o(pres_done_o),
    .restore_pulse_o(restore_pulse_o), .restore_bank_o(restore_bank_o), .refresh_step_o(refresh_step_o));
`default_nettype wire

/* dv/targeted_row_refresh_sequencer_tb.sv */
// Self-checking bench for the targeted refresh sequencer
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin error_cnt++; $display("BAD t=%0t %h %h", $time, a, b); end end
module targeted_row_refresh_sequencer_tb;
    import trs_pkg::*;
    logic       mclk_i = 1'b0;
    logic       rst_n_i = 1'b0;
    trs_req_t   req;
    logic [7:0] ctrl;
    logic [2:0] acts, pres, rbank;
    logic       act_o, step, rest;
    logic [1:0] hits;
    int         error_cnt = 0;
    int         cmp_count = 0;
    int         cyc = 0;
    int         rest_cnt = 0;
    int         rest_base = 0;
    always #4 mclk_i = ~mclk_i;
    trs_host host (.mclk_i(mclk_i), .req_o(req));
    trs_seq dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .req_i(req), .ctrl_o(ctrl), .mode_active_o(act_o),
        .acts_done_o(acts), .pres_done_o(pres), .restore_pulse_o(rest), .restore_bank_o(rbank),
        .refresh_step_o(step));
    // Tally restore pulses; the edge sees the value that stood through the cycle before it
    always @(posedge mclk_i) if (rest) rest_cnt <= rest_cnt + 1;
    // Cut a hung run short
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            error_cnt++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Refresh, then count step pulses over the answer window
    task automatic ref_steps(input logic [1:0] exp);
        hits = 2'h0;
        host.send(CMD_REF, 3'h0, 8'h00, 0);
        repeat (3) begin
            hits += {1'b0, step};
            @(negedge mclk_i);
        end
        `CHK(hits, exp)
    endtask
    // ==========
    // Main sequence
    initial begin
        repeat (16) @(negedge mclk_i);
        rst_n_i = 1'b1;
        `CHK({ctrl, act_o, acts, pres}, 15'h0000)
        for (int b = 0; b < 8; b++) begin
            rest_base = rest_cnt;
            host.trr_run(b[2:0], b[0]);
            `CHK({acts, pres, rbank}, {6'h1b, b[2:0]})
            `CHK(rest_cnt - rest_base, 3)
            repeat (10) @(negedge mclk_i);
            `CHK({ctrl, act_o}, {1'b0, b[2:0], 5'h00})
        end
        // Interrupted run: wrong bank, refused enable, refresh held off
        rest_base = rest_cnt;
        host.send(CMD_MRW, 3'h6, 8'he0, 3);
        host.send(CMD_ACT, 3'h2, 8'h00, 1);
        host.send(CMD_ACT, 3'h6, 8'h00, 1);
        host.send(CMD_MRW, 3'h6, 8'hf0, 1);
        `CHK({ctrl, act_o, acts}, {8'he0, 4'h9})
        `CHK(rest_cnt - rest_base, 1)
        ref_steps(2'h0);
        host.trr_abort(3'h6);
        `CHK({ctrl, acts, pres}, 14'h1800)
        // Unlimited count never starts a run
        host.send(CMD_MRW, 3'h0, 8'h88, 1);
        `CHK({ctrl, act_o}, 9'h110)
        host.send(CMD_MRW, 3'h0, 8'h08, 1);
        ref_steps(2'h1);
        report_and_stop();
    end
endmodule
`default_nettype wire
